// ### bench/swdt_assertions.sv
// checker of the watchdog apb answer and overflow outputs
`timescale 1ns/1ps

module swdt_checker
#(
    parameter int ADDR_W = 12
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic prewarn_irq,
    input wire logic reset_req
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic acc; // access phase of a transfer
    logic hit; // aligned word among the four registers
    assign acc = psel && penable;
    assign hit = (paddr[ADDR_W-1:4] == '0) && (paddr[1:0] == 2'h0);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    ready_now_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    err_unmapped_a: assert property (acc && !hit |-> pslverr)
        else $error("no error on unmapped access");
    err_mapped_a: assert property (acc && hit |-> !pslverr)
        else $error("error on mapped access");
    cmd_zero_a: assert property (acc && !pwrite && paddr == 12'h008
        |-> prdata == 32'h0) else $error("command word reads nonzero");
    warn_first_a: assert property ($rose(reset_req)
        |-> $past(prewarn_irq))
        else $error("reset request without prewarning");
    one_state_a: assert property (!(prewarn_irq && reset_req))
        else $error("prewarning and reset request together");
    req_hold_a: assert property (reset_req |=> reset_req)
        else $error("reset request dropped");
    warn_min_a: assert property ($rose(prewarn_irq) |-> prewarn_irq[*4])
        else $error("prewarning shorter than one tick");
    warn_ends_a: assert property ($fell(prewarn_irq) |-> reset_req)
        else $error("prewarning ended without reset request");
    wake_quiet_a: assert property ($fell(rst)
        |-> !prewarn_irq && !reset_req)
        else $error("alarm outputs set after reset");
    cover property ($rose(prewarn_irq));
    cover property ($rose(reset_req));
    cover property (acc && !hit);
endmodule

bind swdt_top swdt_checker #(.ADDR_W(ADDR_W)) swdt_checker_i (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prewarn_irq(prewarn_irq), .reset_req(reset_req));

// ### bench/tb_system_watchdog_timer.sv
// self-checking bench of the system watchdog timer
`timescale 1ns/1ps
`include "swdt_consts.svh"

module tb_system_watchdog_timer;
    localparam int DFAST = 4; // shortened ratios keep the run short
    localparam int DSLOW = 16;
    localparam int WARN = 2; // prewarning ticks
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prewarn_irq;
    logic reset_req;
    logic [31:0] rd; // read data of the last transfer
    logic err; // error answer of the last transfer
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int rl, dv, n, k, c1; // model: reload, ratio, ticks, counts

    swdt_top #(.DIV_SLOW(DSLOW), .DIV_FAST(DFAST), .PREWARN_TICKS(WARN))
    swdt_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prewarn_irq(prewarn_irq),
        .reset_req(reset_req));

    always #4 clk = ~clk;

    task stop_test();
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; holds the request until pready at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // edges until prewarning (w=1) or reset request (w=0) shows
    task count_to(input bit w);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while ((w ? prewarn_irq : reset_req) !== 1'b1 && k < 5000);
    endtask

    initial
    begin
        void'($urandom(32'hf80c));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `SWDT_OFF_CTRL, 32'h0);
        check("ctrl", rd, 32'h1);
        apb(1'b0, `SWDT_OFF_RELOAD, 32'h0);
        check("reload", rd, 32'hFF02);
        apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
        check("enabled", rd[16], 1'b1);
        check("cnt", rd[15:0] >= 16'hFF02 && rd[15:0] < 16'hFF06, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", err, 1'b1);
        apb(1'b0, `SWDT_OFF_CMD, 32'h0);
        check("cmd_rd", rd, 32'h0);
        // disable freezes the count, enable resumes it
        apb(1'b1, `SWDT_OFF_CMD, 32'h2);
        apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
        c1 = int'(rd[15:0]);
        check("off", rd[16], 1'b0);
        repeat (40) @(posedge clk);
        apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
        check("frozen", rd[15:0], c1);
        apb(1'b1, `SWDT_OFF_CMD, 32'h4);
        repeat (40) @(posedge clk);
        apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
        check("on", rd[16], 1'b1);
        check("moving", int'(rd[15:0]) > c1, 1'b1);
        // both bits in one write: enable wins
        apb(1'b1, `SWDT_OFF_CMD, 32'h6);
        apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
        check("both", rd[16], 1'b1);
        // regular service keeps the alarm away; count restarts at reload
        apb(1'b1, `SWDT_OFF_RELOAD, 32'hFFF0);
        for (int j = 0; j < 6; j++)
        begin
            apb(1'b1, `SWDT_OFF_CMD, 32'h1);
            apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
            check("svc_cnt", rd[15:0], 32'hFFF0);
            repeat (20 + $urandom_range(20)) @(posedge clk);
            check("svc_warn", prewarn_irq, 1'b0);
        end
        // random reload, both ratios, run to overflow and reset request
        for (int i = 0; i < 4; i++)
        begin
            rl = 32'hFFE0 + $urandom_range(15);
            dv = (i % 2) ? DSLOW : DFAST;
            n = 65536 - rl;
            apb(1'b1, `SWDT_OFF_CTRL, (i % 2) ? 32'h0 : 32'h1);
            apb(1'b1, `SWDT_OFF_RELOAD, rl);
            apb(1'b0, `SWDT_OFF_RELOAD, 32'h0);
            check("rl", rd, rl);
            apb(1'b1, `SWDT_OFF_CMD, 32'h1);
            count_to(1'b1);
            check("to_warn", k >= n * dv - 3 && k <= n * dv + 3, 1'b1);
            // a late service is ignored: the request still follows
            c1 = 0;
            if (i % 2)
            begin
                apb(1'b1, `SWDT_OFF_CMD, 32'h1);
                c1 = 3;
            end
            count_to(1'b0);
            k = k + c1 - WARN * dv;
            check("to_req", k >= -3 && k <= 3, 1'b1);
            apb(1'b0, `SWDT_OFF_STATUS, 32'h0);
            check("st", rd[18:17], 2'b10);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
        end
        stop_test();
    end
endmodule

// ### rtl/swdt_consts.svh
// constants for the system watchdog timer: offsets, fields, resets, counts
`ifndef SWDT_CONSTS_SVH
`define SWDT_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------------------
`define SWDT_OFF_CTRL 12'h000
`define SWDT_OFF_RELOAD 12'h004
`define SWDT_OFF_CMD 12'h008
`define SWDT_OFF_STATUS 12'h00C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SWDT_CTRL_FAST_BIT 0
`define SWDT_CMD_SERVICE_BIT 0
`define SWDT_CMD_DISABLE_BIT 1
`define SWDT_CMD_ENABLE_BIT 2
`define SWDT_STAT_ENABLED_BIT 16
`define SWDT_STAT_PREWARN_BIT 17
`define SWDT_STAT_RESREQ_BIT 18

// ----------------------------------------------------------------------
// prescaler ratios and reset values
// ----------------------------------------------------------------------
`define SWDT_DIV_SLOW 16384
`define SWDT_DIV_FAST 256
// 10 MHz reference: 65536 - 0xFF02 = 254 ticks * 256 clocks = 6.5 ms
`define SWDT_RESET_RELOAD 16'hFF02
`define SWDT_RESET_FAST 1'b1
`define SWDT_RESET_ENABLED 1'b1
// prescaler ticks spent in prewarning before the reset request
`define SWDT_PREWARN_TICKS 16
`define SWDT_COUNT_ALL_ONES 16'hFFFF

`endif

// ### rtl/swdt_pkg.sv
// types shared by the system watchdog timer modules
package swdt_pkg;

    // ------------------------------------------------------------------
    // watchdog states, gray coded along run -> warn -> reset request
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SWDT_S_RUN = 2'b00,
        SWDT_S_WARN = 2'b01,
        SWDT_S_RESREQ = 2'b11
    } swdt_state_type;

endpackage

// ### rtl/swdt_prescaler.sv
// prescaler of the system watchdog timer: one-cycle tick enable
`timescale 1ns/1ps
`include "swdt_consts.svh"

module swdt_prescaler
#(
    parameter int DIV_SLOW = `SWDT_DIV_SLOW,
    parameter int DIV_FAST = `SWDT_DIV_FAST
)
(
    input wire logic clk,
    input wire logic rst,
    swdt_tick_if.presc link
);
    localparam int CW = $clog2(DIV_SLOW);
    localparam logic [CW-1:0] LAST_SLOW = CW'(DIV_SLOW - 1);
    localparam logic [CW-1:0] LAST_FAST = CW'(DIV_FAST - 1);

    logic [CW-1:0] div_q; // running divide count
    logic [CW-1:0] last; // terminal count of the chosen ratio

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    assign last = link.fast_sel ? LAST_FAST : LAST_SLOW;

    // clear wins over counting so a service restarts a full interval
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= '0;
        end
        else if (link.clear)
        begin
            div_q <= '0;
        end
        else if (link.run)
        begin
            // a ratio change mid-count may pass the new terminal; wrap
            if (div_q >= last)
            begin
                div_q <= '0;
            end
            else
            begin
                div_q <= div_q + CW'(1);
            end
        end
    end

    // tick is a plain decode; the core registers everything it drives
    assign link.tick = link.run && !link.clear && (div_q >= last);
endmodule

// ### rtl/swdt_tick_if.sv
// link between the watchdog core and its prescaler
`timescale 1ns/1ps

interface swdt_tick_if;
    logic run; // prescaler counts while high
    logic clear; // one-cycle clear of the prescaler
    logic fast_sel; // 1: divide by fast ratio, 0: slow ratio
    logic tick; // one-cycle enable pulse at the divided rate

    // ------------------------------------------------------------------
    // core side drives control, prescaler side drives the tick
    // ------------------------------------------------------------------
    modport core (output run, output clear, output fast_sel, input tick);
    modport presc (input run, input clear, input fast_sel, output tick);
endinterface

// ### rtl/swdt_top.sv
// system watchdog timer: apb registers, counter and overflow sequence
`timescale 1ns/1ps
`include "swdt_consts.svh"

module swdt_top
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 16,
    parameter int DIV_SLOW = `SWDT_DIV_SLOW,
    parameter int DIV_FAST = `SWDT_DIV_FAST,
    parameter int PREWARN_TICKS = `SWDT_PREWARN_TICKS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic prewarn_irq,
    output logic reset_req
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int WW = $clog2(PREWARN_TICKS + 1);

    swdt_tick_if tick_link (); // control to and tick from the prescaler

    logic setup; // apb setup cycle
    logic access; // apb access cycle, always completes at once
    logic wr; // write takes effect this edge
    logic mapped; // address hits a register
    logic [31:0] rdata; // read mux, captured in setup
    logic [31:0] prdata_q; // registered read data
    logic fast_q; // prescaler ratio select
    logic [CNT_W-1:0] reload_q; // watchdog_reload_value
    logic enabled_q; // watchdog running
    logic [CNT_W-1:0] count_q; // watchdog counter
    logic service_q; // registered service, clears prescaler next
    logic [WW-1:0] warn_q; // ticks left in prewarning
    swdt_pkg::swdt_state_type state_q; // overflow sequence state
    logic cmd_wr; // write to the command register
    logic watchdog_service_cmd; // service request from software
    logic watchdog_disable_cmd; // stop request from software
    logic watchdog_enable_cmd; // start request from software
    logic overflow; // counter wraps on this tick

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // phase decode of the bus handshake
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    // zero wait states: the slave never stretches the access phase
    assign pready = 1'b1;

    // address decode
    always_comb
    begin
        case (paddr)
            `SWDT_OFF_CTRL, `SWDT_OFF_RELOAD, `SWDT_OFF_CMD,
            `SWDT_OFF_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error, nothing is written
    assign pslverr = access && !mapped;

    // read mux; command register is write-only and reads as zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (paddr)
            `SWDT_OFF_CTRL: rdata[`SWDT_CTRL_FAST_BIT] = fast_q;
            `SWDT_OFF_RELOAD: rdata[CNT_W-1:0] = reload_q;
            `SWDT_OFF_STATUS:
            begin
                rdata[CNT_W-1:0] = count_q;
                rdata[`SWDT_STAT_ENABLED_BIT] = enabled_q;
                rdata[`SWDT_STAT_PREWARN_BIT] = prewarn_irq;
                rdata[`SWDT_STAT_RESREQ_BIT] = reset_req;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // read data is sampled in the setup cycle so prdata is a flop output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (setup && !pwrite)
        begin
            prdata_q <= rdata;
        end
    end

    // data output straight from the flop, no decode after it
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // ratio select; reset default is the fast ratio for the 6.5 ms figure
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fast_q <= `SWDT_RESET_FAST;
        end
        else if (wr && paddr == `SWDT_OFF_CTRL)
        begin
            fast_q <= pwdata[`SWDT_CTRL_FAST_BIT];
        end
    end

    // reload value; takes effect at the next service only, an overflow wraps the count through zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reload_q <= CNT_W'(`SWDT_RESET_RELOAD);
        end
        else if (wr && paddr == `SWDT_OFF_RELOAD)
        begin
            reload_q <= pwdata[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // commands
    // ------------------------------------------------------------------
    // one-cycle command strobes, valid only at the write edge
    // nothing is sticky: a later write with a bit clear does nothing
    assign cmd_wr = wr && (paddr == `SWDT_OFF_CMD);
    assign watchdog_service_cmd = cmd_wr && pwdata[`SWDT_CMD_SERVICE_BIT];
    assign watchdog_disable_cmd = cmd_wr && pwdata[`SWDT_CMD_DISABLE_BIT];
    assign watchdog_enable_cmd = cmd_wr && pwdata[`SWDT_CMD_ENABLE_BIT];

    // run flag; enable wins if both bits are written together
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enabled_q <= `SWDT_RESET_ENABLED;
        end
        else if (watchdog_enable_cmd)
        begin
            enabled_q <= 1'b1;
        end
        else if (watchdog_disable_cmd)
        begin
            enabled_q <= 1'b0;
        end
    end

    // service is ignored once the overflow sequence started: a late
    // service must not rescue a program that already missed its slot
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            service_q <= 1'b0;
        end
        else
        begin
            // a service in the very cycle of the wrap loses to it
            service_q <= watchdog_service_cmd && !overflow &&
                (state_q == swdt_pkg::SWDT_S_RUN);
        end
    end

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    // the prescaler stops when disabled or once the reset request stands
    assign tick_link.run = enabled_q && (state_q != swdt_pkg::SWDT_S_RESREQ);
    assign tick_link.clear = service_q;
    // a ratio change applies to the running count at once
    assign tick_link.fast_sel = fast_q;

    swdt_prescaler
    #(
        .DIV_SLOW(DIV_SLOW),
        .DIV_FAST(DIV_FAST)
    )
    swdt_prescaler_i
    (
        .clk(clk),
        .rst(rst),
        .link(tick_link.presc)
    );

    // ------------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------------
    // wrap of an all-ones count on a tick is the overflow event
    assign overflow = tick_link.tick &&
        (count_q == `SWDT_COUNT_ALL_ONES);

    // counts up from the reload value; service reloads it, overflow
    // wraps through zero as the sequence proceeds
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= CNT_W'(`SWDT_RESET_RELOAD);
        end
        else if (service_q)
        begin
            count_q <= reload_q;
        end
        // disabled: no tick comes, so the count holds its value
        else if (tick_link.tick)
        begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // overflow sequence: prewarning first, reset request afterwards
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= swdt_pkg::SWDT_S_RUN;
        end
        else
        begin
            case (state_q)
                swdt_pkg::SWDT_S_RUN:
                begin
                    // a timely service keeps the count below the wrap
                    // unserviced wrap starts the prewarning
                    if (overflow)
                    begin
                        state_q <= swdt_pkg::SWDT_S_WARN;
                    end
                end
                swdt_pkg::SWDT_S_WARN:
                begin
                    // disable pauses the window: no ticks while stopped
                    // reset request after the prewarning window
                    if (tick_link.tick && warn_q == WW'(1))
                    begin
                        state_q <= swdt_pkg::SWDT_S_RESREQ;
                    end
                end
                swdt_pkg::SWDT_S_RESREQ:
                begin
                    // held until the chip reset clears the block
                    state_q <= swdt_pkg::SWDT_S_RESREQ;
                end
                default: state_q <= swdt_pkg::SWDT_S_RUN;
            endcase
        end
    end

    // prewarning window, measured in prescaler ticks
    // held full while running so the window always opens complete
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            warn_q <= WW'(PREWARN_TICKS);
        end
        else if (state_q == swdt_pkg::SWDT_S_RUN)
        begin
            warn_q <= WW'(PREWARN_TICKS);
        end
        else if (state_q == swdt_pkg::SWDT_S_WARN && tick_link.tick)
        begin
            warn_q <= warn_q - WW'(1);
        end
    end

    // ------------------------------------------------------------------
    // alarm outputs
    // ------------------------------------------------------------------
    // both flags are registered state decodes, glitch free
    assign prewarn_irq = (state_q == swdt_pkg::SWDT_S_WARN);
    assign reset_req = (state_q == swdt_pkg::SWDT_S_RESREQ);
endmodule
